// File: rtl/cpp_pkg.sv
package cpp_pkg;
    localparam logic [31:0] CLK_KHZ        = 32'h0000_4E20;
    localparam logic [31:0] HICCUP_ON_MS   = 32'h0000_03E8;
    localparam int unsigned HICCUP_ON_CYC  = int'(HICCUP_ON_MS * CLK_KHZ);
    localparam logic [31:0] IDLE_CNT_RST   = 32'h0098_9680;

    localparam logic [5:0] A_CTRL      = 6'h00;
    localparam logic [5:0] A_PWR_LIM   = 6'h04;
    localparam logic [5:0] A_CUR_LIM   = 6'h08;
    localparam logic [5:0] A_PEAK_LIM  = 6'h0C;
    localparam logic [5:0] A_SHORT_LIM = 6'h10;
    localparam logic [5:0] A_TEMP_LIM  = 6'h14;
    localparam logic [5:0] A_IDLE_CNT  = 6'h18;
    localparam logic [5:0] A_KP_KI     = 6'h1C;
    localparam logic [5:0] A_KD_ALPHA  = 6'h20;
    localparam logic [5:0] A_SCALE     = 6'h24;
    localparam logic [5:0] A_STATUS    = 6'h28;
    localparam logic [5:0] A_DUTY      = 6'h2C;

    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam int SC_SHIFT_LSB = 16;
    localparam int SC_PRD_LSB   = 20;
    localparam int ST_STATE_LSB = 8;

    // Power in mW (10 mV x 100 mA), currents in 100 mA, temperatures in 0.1 C
    localparam logic [31:0] PWR_LIM_RST   = 32'h0005_7E40;
    localparam logic [15:0] CUR_LIM_RST   = 16'h0168;
    localparam logic [15:0] PEAK_LIM_RST  = 16'h00A0;
    localparam logic [15:0] SHORT_LIM_RST = 16'h0168;
    localparam logic [11:0] TEMP_LIM_RST  = 12'h04E2;
    localparam logic [11:0] TEMP_REF      = 12'h00FA;
    localparam int          TCO_SHIFT     = 12;
    localparam logic [15:0] KP_RST        = 16'h0100;
    localparam logic [15:0] KI_RST        = 16'h0010;
    localparam logic [15:0] KD_RST        = 16'h0000;
    localparam logic [7:0]  ALPHA_RST     = 8'h00;
    localparam logic [15:0] GAIN_RST      = 16'h0800;
    localparam logic [3:0]  SHIFT_RST     = 4'h0;
    localparam logic [10:0] PRD_RST       = 11'h0FF;

    localparam int ALPHA_SHIFT = 8;
    localparam int GAIN_SHIFT  = 19;
    localparam int NORM_SHIFT  = 4;

    localparam int FL_OUT_OV = 0;
    localparam int FL_OVERCUR = 1;
    localparam int FL_SHORT = 2;
    localparam int FL_OVERTEMP = 3;
    localparam int FL_IN_OV = 4;
    localparam int FL_PWR_LIM = 5;
    localparam int FL_PEAK = 6;
    localparam int NFLAGS = 7;

    typedef enum logic [2:0] {ST_OFF, ST_RUN, ST_HIC_ON, ST_HIC_IDLE, ST_LATCH} cpp_state_e;
endpackage

// File: rtl/cpp_pid_if.sv
`timescale 1ns/100ps
interface cpp_pid_if;
    logic               sample;
    logic signed [15:0] err;
    logic signed [15:0] kp;
    logic signed [15:0] ki;
    logic signed [15:0] kd;
    logic        [7:0]  alpha;
    logic        [3:0]  shift;
    logic        [15:0] gain;
    logic        [10:0] period;
    logic        [15:0] out;
    modport ctl (output sample, err, kp, ki, kd, alpha, shift, gain, period, input out);
    modport pid (input sample, err, kp, ki, kd, alpha, shift, gain, period, output out);
endinterface

// File: rtl/cpp_pid.sv
`timescale 1ns/100ps
module cpp_pid import cpp_pkg::*; (
    input  wire logic  i_clk,
    input  wire logic  i_reset,
    cpp_pid_if.pid     bus
);
    logic signed [15:0] e_prev_reg;
    logic signed [31:0] int_reg;
    logic signed [31:0] der_reg;
    logic        [15:0] out_reg;

    wire signed [16:0] e_sum   = {bus.err[15], bus.err} + {e_prev_reg[15], e_prev_reg};
    wire signed [16:0] e_dif   = {bus.err[15], bus.err} - {e_prev_reg[15], e_prev_reg};
    wire signed [31:0] p_term  = bus.kp * bus.err;
    wire signed [32:0] i_prod  = bus.ki * e_sum;
    wire signed [31:0] int_nxt = int_reg + i_prod[31:0];
    wire signed [32:0] d_prod  = bus.kd * e_dif;
    wire signed [40:0] a_prod  = der_reg * $signed({1'b0, bus.alpha});
    wire signed [40:0] a_scl   = a_prod >>> ALPHA_SHIFT;
    wire signed [31:0] der_nxt = d_prod[31:0] + a_scl[31:0];
    wire signed [31:0] sum     = p_term + int_nxt + der_nxt;
    wire signed [31:0] shifted = sum >>> bus.shift;
    wire signed [48:0] g_prod  = shifted * $signed({1'b0, bus.gain});
    wire signed [48:0] g_scl   = g_prod >>> GAIN_SHIFT;
    // Full scale of the pulse width is 2^4 * (period + 1) ticks
    wire        [15:0] f_scale = {12'(bus.period) + 12'h001, 4'h0};
    wire               neg     = g_scl[48];
    wire               over    = !neg && (g_scl[47:16] != 32'h0000_0000 || g_scl[15:0] > f_scale);
    wire        [15:0] clamped = neg ? 16'h0000 : (over ? f_scale : g_scl[15:0]);

    assign bus.out = out_reg;

    // Integrator wraps without saturation; keep ki small enough for the operating range
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            e_prev_reg <= 16'sh0000;
            int_reg    <= 32'sh0000_0000;
            der_reg    <= 32'sh0000_0000;
            out_reg    <= 16'h0000;
        end else if (bus.sample) begin
            e_prev_reg <= bus.err;
            int_reg    <= int_nxt;
            der_reg    <= der_nxt;
            out_reg    <= clamped;
        end
    end

    a_out_bounded: assert property (@(posedge i_clk) disable iff (i_reset)
        bus.sample |=> out_reg <= $past(f_scale))
        else $error("Compensator output above full scale");
    a_hold_nosample: assert property (@(posedge i_clk) disable iff (i_reset)
        !bus.sample |=> $stable(int_reg) && $stable(out_reg))
        else $error("Compensator state moved without a sample");
endmodule

// File: rtl/cpp_top.sv
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/100ps
module cpp_top import cpp_pkg::*; #(
    parameter int unsigned P_HICCUP_ON_CYC = HICCUP_ON_CYC,
    parameter logic [31:0] P_IDLE_RESET    = IDLE_CNT_RST
) (
    input  wire logic               i_clk,
    input  wire logic               i_reset,
    input  wire logic        [5:0]  i_addr,
    input  wire logic        [31:0] i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    output logic             [31:0] o_rdata,
    input  wire logic               i_power_on_switch,
    input  wire logic               i_overvoltage_sense,
    input  wire logic               i_input_overvoltage,
    input  wire logic        [15:0] i_peak_current,
    input  wire logic        [15:0] i_load_current,
    input  wire logic        [15:0] i_out_voltage,
    input  wire logic        [11:0] i_die_temp,
    input  wire logic        [11:0] i_external_temp,
    input  wire logic               i_cycle_start,
    input  wire logic        [1:0]  i_pwm_raw,
    input  wire logic               i_sample,
    input  wire logic signed [15:0] i_volt_err,
    input  wire logic signed [15:0] i_cur_err,
    output logic             [1:0]  o_digital_pwm_output,
    output logic             [15:0] o_duty,
    output logic                    o_current_loop,
    output logic                    o_latched,
    output logic                    o_alert
);
    function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
        hit = (a == off);
    endfunction

    cpp_pid_if if_v ();
    cpp_pid_if if_c ();

    logic              en_reg;
    logic       [31:0] pwr_lim_reg;
    logic       [15:0] cur_lim_reg;
    logic       [15:0] peak_lim_reg;
    logic       [15:0] short_lim_reg;
    logic       [11:0] temp_lim_reg;
    logic       [31:0] idle_reg;
    logic       [15:0] kp_reg;
    logic       [15:0] ki_reg;
    logic       [15:0] kd_reg;
    logic       [7:0]  alpha_reg;
    logic       [15:0] gain_reg;
    logic       [3:0]  shift_reg;
    logic       [10:0] period_reg;
    logic [NFLAGS-1:0] flags_reg;
    logic [NFLAGS-1:0] flags_next;
    cpp_state_e        state_reg;
    cpp_state_e        state_next;
    logic       [31:0] cnt_reg;
    logic       [31:0] cnt_next;
    logic              trunc_reg;
    logic       [31:0] rdata_next;

    // Register decode
    wire wr_ctrl  = i_wr && hit(i_addr, A_CTRL);
    wire clear    = wr_ctrl && i_wdata[CTRL_CLR_BIT];

    // Shunt drift correction from the external sensor
    wire [11:0] t_delta   = (i_external_temp > TEMP_REF) ? i_external_temp - TEMP_REF : 12'h000;
    wire [27:0] corr_prod = i_load_current * t_delta;
    wire [15:0] load_corr = i_load_current + corr_prod[TCO_SHIFT+15:TCO_SHIFT];
    wire [31:0] out_power = i_out_voltage * load_corr;

    wire power_hit = en_reg && out_power >= pwr_lim_reg;
    wire cc_hit    = en_reg && load_corr >= cur_lim_reg;
    wire cur_wins  = if_c.out > if_v.out;
    wire takeover  = en_reg && cur_wins;
    wire short_hit = load_corr > short_lim_reg;
    wire ot_hit    = i_die_temp > temp_lim_reg || i_external_temp > temp_lim_reg;
    wire hic_cause = takeover || cc_hit || short_hit || ot_hit;
    wire peak_hit  = i_peak_current > peak_lim_reg;
    wire ov        = i_overvoltage_sense;
    wire latched   = state_reg == ST_LATCH;

    // Protection sequencer
    always_comb begin
        state_next = state_reg;
        if (!i_power_on_switch) begin
            state_next = ST_OFF;
        end else if (ov) begin
            state_next = ST_LATCH;
        end else begin
            unique case (state_reg)
                ST_OFF:      state_next = ST_RUN;
                ST_RUN:      if (hic_cause) state_next = ST_HIC_ON;
                ST_HIC_ON:   if (cnt_reg == 32'(P_HICCUP_ON_CYC - 1)) state_next = ST_HIC_IDLE;
                ST_HIC_IDLE: if (cnt_reg >= idle_reg) state_next = ST_RUN;
                ST_LATCH:    state_next = ST_LATCH;
            endcase
        end
    end

    wire counting = state_next == state_reg && (state_reg == ST_HIC_ON || state_reg == ST_HIC_IDLE);
    assign cnt_next = counting ? cnt_reg + 32'h0000_0001 : 32'h0000_0000;

    // Power limit is not a fault path: the stage keeps switching while it holds
    wire        running    = state_next == ST_RUN || state_next == ST_HIC_ON;
    wire        trunc_next = peak_hit || (trunc_reg && !i_cycle_start);
    wire [1:0]  pwm_next   = (running && !trunc_next) ? i_pwm_raw : 2'b00;
    wire        loop_next  = cur_wins || state_next == ST_HIC_ON;
    wire [15:0] sel_out    = loop_next ? if_c.out : if_v.out;
    wire [15:0] duty_lim   = (power_hit && sel_out > o_duty) ? o_duty : sel_out;
    wire [15:0] duty_next  = running ? duty_lim : 16'h0000;

    // Sticky flags: a set in the clear cycle wins; the latching fault survives a clear
    wire [NFLAGS-1:0] flag_set = {peak_hit, power_hit, i_input_overvoltage, ot_hit,
                                  short_hit, takeover || cc_hit, ov};
    wire [NFLAGS-1:0] clr_mask = clear ? {{(NFLAGS-1){1'b1}}, !latched} : '0;
    assign flags_next = !i_power_on_switch ? '0 : ((flags_reg & ~clr_mask) | flag_set);

    wire [31:0] status = {21'h00_0000, 3'(state_reg), 1'b0, flags_reg};
    assign rdata_next = !i_rd                        ? 32'h0000_0000 :
                        hit(i_addr, A_CTRL)      ? {31'h0000_0000, en_reg} :
                        hit(i_addr, A_PWR_LIM)   ? pwr_lim_reg :
                        hit(i_addr, A_CUR_LIM)   ? {16'h0000, cur_lim_reg} :
                        hit(i_addr, A_PEAK_LIM)  ? {16'h0000, peak_lim_reg} :
                        hit(i_addr, A_SHORT_LIM) ? {16'h0000, short_lim_reg} :
                        hit(i_addr, A_TEMP_LIM)  ? {20'h0_0000, temp_lim_reg} :
                        hit(i_addr, A_IDLE_CNT)  ? idle_reg :
                        hit(i_addr, A_KP_KI)     ? {ki_reg, kp_reg} :
                        hit(i_addr, A_KD_ALPHA)  ? {8'h00, alpha_reg, kd_reg} :
                        hit(i_addr, A_SCALE)     ? {1'b0, period_reg, shift_reg, gain_reg} :
                        hit(i_addr, A_STATUS)    ? status :
                        hit(i_addr, A_DUTY)      ? {16'h0000, o_duty} : 32'h0000_0000;

    // Compensator wiring; both loops share one coefficient set
    assign if_v.sample = i_sample;
    assign if_v.err    = i_volt_err;
    assign if_c.sample = i_sample;
    assign if_c.err    = i_cur_err;
    assign {if_v.kp, if_v.ki, if_v.kd, if_v.alpha} = {kp_reg, ki_reg, kd_reg, alpha_reg};
    assign {if_c.kp, if_c.ki, if_c.kd, if_c.alpha} = {kp_reg, ki_reg, kd_reg, alpha_reg};
    assign {if_v.shift, if_v.gain, if_v.period} = {shift_reg, gain_reg, period_reg};
    assign {if_c.shift, if_c.gain, if_c.period} = {shift_reg, gain_reg, period_reg};

    cpp_pid u_pid_volt (.i_clk(i_clk), .i_reset(i_reset), .bus(if_v));
    cpp_pid u_pid_cur  (.i_clk(i_clk), .i_reset(i_reset), .bus(if_c));

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            en_reg        <= 1'b1;
            pwr_lim_reg   <= PWR_LIM_RST;
            cur_lim_reg   <= CUR_LIM_RST;
            peak_lim_reg  <= PEAK_LIM_RST;
            short_lim_reg <= SHORT_LIM_RST;
            temp_lim_reg  <= TEMP_LIM_RST;
            idle_reg      <= P_IDLE_RESET;
        end else if (i_wr) begin
            if (hit(i_addr, A_CTRL))      en_reg        <= i_wdata[CTRL_EN_BIT];
            if (hit(i_addr, A_PWR_LIM))   pwr_lim_reg   <= i_wdata;
            if (hit(i_addr, A_CUR_LIM))   cur_lim_reg   <= i_wdata[15:0];
            if (hit(i_addr, A_PEAK_LIM))  peak_lim_reg  <= i_wdata[15:0];
            if (hit(i_addr, A_SHORT_LIM)) short_lim_reg <= i_wdata[15:0];
            if (hit(i_addr, A_TEMP_LIM))  temp_lim_reg  <= i_wdata[11:0];
            if (hit(i_addr, A_IDLE_CNT))  idle_reg      <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            {kp_reg, ki_reg, kd_reg, alpha_reg} <= {KP_RST, KI_RST, KD_RST, ALPHA_RST};
            {gain_reg, shift_reg, period_reg}   <= {GAIN_RST, SHIFT_RST, PRD_RST};
        end else if (i_wr) begin
            if (hit(i_addr, A_KP_KI))    {ki_reg, kp_reg} <= i_wdata;
            if (hit(i_addr, A_KD_ALPHA)) {alpha_reg, kd_reg} <= i_wdata[23:0];
            if (hit(i_addr, A_SCALE)) begin
                gain_reg   <= i_wdata[15:0];
                shift_reg  <= i_wdata[SC_SHIFT_LSB +: 4];
                period_reg <= i_wdata[SC_PRD_LSB +: 11];
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg            <= ST_OFF;
            cnt_reg              <= 32'h0000_0000;
            trunc_reg            <= 1'b0;
            flags_reg            <= '0;
            o_digital_pwm_output <= 2'b00;
            o_duty               <= 16'h0000;
            o_current_loop       <= 1'b0;
            o_latched            <= 1'b0;
            o_alert              <= 1'b0;
            o_rdata              <= 32'h0000_0000;
        end else begin
            state_reg            <= state_next;
            cnt_reg              <= cnt_next;
            trunc_reg            <= trunc_next;
            flags_reg            <= flags_next;
            o_digital_pwm_output <= pwm_next;
            o_duty               <= duty_next;
            o_current_loop       <= loop_next;
            o_latched            <= state_next == ST_LATCH;
            o_alert              <= |flags_next;
            o_rdata              <= rdata_next;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    a_ovp_latch: assert property (i_power_on_switch && ov |=> latched && o_latched)
        else $error("Overvoltage did not latch off");
    a_ovp_pulses: assert property (ov |=> o_digital_pwm_output == 2'b00)
        else $error("Pulses kept running under overvoltage");
    a_latch_holds: assert property (latched && i_power_on_switch |=> latched)
        else $error("Latch left while switch stayed on");
    a_switch_off: assert property (!i_power_on_switch |=> state_reg == ST_OFF && flags_reg == '0)
        else $error("Switch off did not reset state and flags");
    a_peak_trunc: assert property (peak_hit |=> o_digital_pwm_output == 2'b00)
        else $error("Peak current did not truncate pulses");
    a_trunc_holds: assert property (trunc_reg && !i_cycle_start |=> o_digital_pwm_output == 2'b00)
        else $error("Pulses resumed before next switching cycle");
    a_takeover_hic: assert property (state_reg == ST_RUN && i_power_on_switch && !ov && takeover
        |=> state_reg == ST_HIC_ON ##0 o_current_loop)
        else $error("Current loop takeover missed hiccup");
    a_hic_causes: assert property (state_reg == ST_RUN && i_power_on_switch && !ov
        && (short_hit || ot_hit || cc_hit) |=> state_reg == ST_HIC_ON)
        else $error("Fault did not lead to hiccup");
    a_hic_on_time: assert property (state_reg == ST_HIC_ON && cnt_reg == 32'(P_HICCUP_ON_CYC - 1)
        && i_power_on_switch && !ov |=> state_reg == ST_HIC_IDLE)
        else $error("Hiccup on time wrong");
    a_idle_restart: assert property (state_reg == ST_HIC_IDLE && cnt_reg >= idle_reg
        && i_power_on_switch && !ov |=> state_reg == ST_RUN)
        else $error("Hiccup did not restart after idle");
    a_power_nolatch: assert property (!ov && state_reg != ST_LATCH |=> state_reg != ST_LATCH)
        else $error("Latch entered without overvoltage");
    a_inov_warn: assert property (i_input_overvoltage && i_power_on_switch
        |=> flags_reg[FL_IN_OV] && o_alert)
        else $error("Input overvoltage warning missing");
    a_flag_sticky: assert property (flags_reg[FL_SHORT] && !clear && i_power_on_switch
        |=> flags_reg[FL_SHORT])
        else $error("Sticky flag dropped");

    c_hic_cycle: cover property (state_reg == ST_HIC_IDLE ##1 state_reg == ST_RUN);
    c_latched: cover property (state_reg == ST_LATCH);
    c_trunc: cover property (trunc_reg && i_pwm_raw != 2'b00);
    c_power_limit: cover property (power_hit && state_reg == ST_RUN);
endmodule

// File: sim/cpp_stage_model.sv
`timescale 1ns/100ps
module cpp_stage_model #(
    parameter int PERIOD = 8
) (
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    output logic            o_cycle_start,
    output logic      [1:0] o_pwm_raw
);
    logic [7:0] cnt_reg;
    // Dead time at the cycle edge and mid-cycle so the two legs never overlap
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt_reg       <= 8'h00;
            o_cycle_start <= 1'b0;
            o_pwm_raw     <= 2'b00;
        end else begin
            cnt_reg       <= (cnt_reg == 8'(PERIOD - 1)) ? 8'h00 : cnt_reg + 8'h01;
            o_cycle_start <= (cnt_reg == 8'h00);
            o_pwm_raw     <= {cnt_reg >= 8'h05, cnt_reg inside {8'h01, 8'h02, 8'h03}};
        end
    end
endmodule

// File: sim/tb_top.sv
`timescale 1ns/100ps
module tb_top import cpp_pkg::*; ();
    logic               clk, rst, wr, rd, sw, ovs, inov, cs, cur_loop, latched, alert;
    logic        [5:0]  addr;
    logic        [31:0] wdata, rdata, st, held;
    logic        [15:0] peak, load, volt, duty;
    logic        [11:0] die, ext;
    logic        [1:0]  raw, raw_d, pwm;
    logic signed [15:0] verr, cerr;
    int                 failures = 0, n_checks = 0, cyc = 0;
    logic        [5:0]  ra [7] = '{A_CTRL, A_PWR_LIM, A_CUR_LIM, A_PEAK_LIM, A_SHORT_LIM, A_IDLE_CNT, 6'h30};
    logic        [31:0] re [7];

    // Short hiccup counts keep the run brief; expectations below follow these values
    cpp_top #(.P_HICCUP_ON_CYC(50), .P_IDLE_RESET(32'h0000_0014)) cpp_top_i (
        .i_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_power_on_switch(sw), .i_overvoltage_sense(ovs), .i_input_overvoltage(inov), .i_peak_current(peak),
        .i_load_current(load), .i_out_voltage(volt), .i_die_temp(die), .i_external_temp(ext),
        .i_cycle_start(cs), .i_pwm_raw(raw), .i_sample(cs), .i_volt_err(verr), .i_cur_err(cerr),
        .o_digital_pwm_output(pwm), .o_duty(duty), .o_current_loop(cur_loop), .o_latched(latched),
        .o_alert(alert));
    cpp_stage_model cpp_stage_model_i (.i_clk(clk), .i_reset(rst), .o_cycle_start(cs), .o_pwm_raw(raw));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        raw_d <= raw;
        cyc   <= cyc + 1;
        if (cyc == 2000) begin
            failures++;
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [5:0] a);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1 st = rdata;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check_pass(input int n);
        repeat (n) begin
            @(posedge clk);
            #1 chk("pwm", 32'(raw_d), 32'(pwm));
        end
    endtask
    task automatic done(input string s);
        $display("End of %s test", s);
    endtask
    task automatic complete_run();
        $display("Checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        re = '{32'h0000_0001, PWR_LIM_RST, 32'(CUR_LIM_RST), 32'(PEAK_LIM_RST), 32'(SHORT_LIM_RST),
               32'h0000_0014, 32'h0000_0000};
        {rst, sw, wr, rd, ovs, inov} = 6'b11_0000;
        {addr, wdata, peak, cerr} = '0;
        {load, volt, die, ext, verr} = {16'h0064, 16'h04B0, 12'h12C, 12'h0C8, 16'h0064};
        repeat (12) @(posedge clk);
        #1 chk("outputs in reset", 32'h0000_0000, {28'h0, pwm, latched, alert});
        @(posedge clk);
        rst <= 1'b0;
        foreach (ra[i]) begin
            rd_reg(ra[i]);
            chk("reset value", re[i], st);
        end
        check_pass(8);
        done("register");
        @(posedge clk);
        peak <= 16'h00C8;
        repeat (10) begin
            @(posedge clk);
            #1 chk("truncated pwm", 32'h0000_0000, 32'(pwm));
        end
        @(posedge clk);
        peak <= 16'h0000;
        wait_cyc(10);
        check_pass(8);
        rd_reg(A_STATUS);
        chk("peak flag", 32'h0000_0140, st);
        wr_reg(A_CTRL, 32'h0000_0003);
        rd_reg(A_STATUS);
        chk("cleared status", 32'h0000_0100, st);
        done("truncation");
        wr_reg(A_PWR_LIM, 32'h0001_86A0);
        check_pass(8);
        rd_reg(A_STATUS);
        chk("power limit status", 32'h0000_0120, st);
        rd_reg(A_DUTY);
        held = st;
        wait_cyc(16);
        rd_reg(A_DUTY);
        chk("held duty", held, st);
        wr_reg(A_PWR_LIM, PWR_LIM_RST);
        @(posedge clk);
        inov <= 1'b1;
        wait_cyc(3);
        rd_reg(A_STATUS);
        chk("input ov status", 32'h0000_0130, st);
        chk("alert", 32'h0000_0001, 32'(alert));
        @(posedge clk);
        inov <= 1'b0;
        wr_reg(A_CTRL, 32'h0000_0003);
        rd_reg(A_STATUS);
        chk("warning cleared", 32'h0000_0100, st);
        done("warning");
        @(posedge clk);
        load <= 16'h0190;
        @(posedge clk);
        #1 chk("current loop", 32'h0000_0001, 32'(cur_loop));
        @(posedge clk);
        load <= 16'h0064;
        wait_cyc(18);
        rd_reg(A_STATUS);
        chk("hiccup on", {29'h0, 3'(ST_HIC_ON)}, 32'(st[10:8]));
        chk("short flag", 32'h0000_0001, 32'(st[2]));
        wait_cyc(35);
        rd_reg(A_STATUS);
        chk("hiccup idle", {29'h0, 3'(ST_HIC_IDLE)}, 32'(st[10:8]));
        chk("idle pwm", 32'h0000_0000, 32'(pwm));
        wait_cyc(25);
        rd_reg(A_STATUS);
        chk("restart", {29'h0, 3'(ST_RUN)}, 32'(st[10:8]));
        chk("voltage loop back", 32'h0000_0000, 32'(cur_loop));
        check_pass(8);
        @(posedge clk);
        load <= 16'h0190;
        wait_cyc(84);
        rd_reg(A_STATUS);
        chk("hiccup again", {29'h0, 3'(ST_HIC_ON)}, 32'(st[10:8]));
        done("hiccup");
        @(posedge clk);
        ovs  <= 1'b1;
        load <= 16'h0064;
        @(posedge clk);
        #1 chk("latch outputs", 32'h0000_0001, {duty, 13'h0, pwm, latched});
        @(posedge clk);
        ovs <= 1'b0;
        wait_cyc(10);
        wr_reg(A_CTRL, 32'h0000_0003);
        rd_reg(A_STATUS);
        chk("latch held", {29'h0, 3'(ST_LATCH)}, 32'(st[10:8]));
        chk("ov flag kept", 32'h0000_0001, 32'(st[0]));
        @(posedge clk);
        sw <= 1'b0;
        wait_cyc(3);
        rd_reg(A_STATUS);
        chk("switch off", 32'h0000_0000, {st[31:1], latched});
        @(posedge clk);
        sw <= 1'b1;
        wait_cyc(5);
        done("latch");
        @(posedge clk);
        ext <= 12'h514;
        wait_cyc(3);
        rd_reg(A_STATUS);
        chk("overtemp", {28'h0, 3'(ST_HIC_ON), 1'b1}, {28'h0, st[10:8], st[3]});
        chk("not latched", 32'h0000_0000, 32'(latched));
        done("temperature");
        wr_reg(A_CTRL, 32'h0000_0000);
        @(posedge clk);
        sw   <= 1'b0;
        ext  <= 12'h0C8;
        load <= 16'h0168;
        @(posedge clk);
        sw <= 1'b1;
        wait_cyc(4);
        rd_reg(A_STATUS);
        chk("limiter off", 32'h0000_0100, st);
        wr_reg(A_CTRL, 32'h0000_0001);
        wait_cyc(2);
        rd_reg(A_STATUS);
        chk("limiter on", {29'h0, 3'(ST_HIC_ON)}, 32'(st[10:8]));
        done("limiter");
        @(posedge clk);
        sw   <= 1'b0;
        ext  <= 12'h4B0;
        load <= 16'h0154;
        @(posedge clk);
        sw <= 1'b1;
        wait_cyc(3);
        rd_reg(A_STATUS);
        chk("corrected short", {29'h0, 3'(ST_HIC_ON)}, 32'(st[10:8]));
        chk("corrected flag", 32'h0000_0001, 32'(st[2]));
        done("shunt");
        complete_run();
    end
endmodule
